// >>> hw/spg_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef SPG_REGS_SVH
`define SPG_REGS_SVH
`define SPG_OFS_CTRL    4'h0
`define SPG_OFS_CMD     4'h4
`define SPG_OFS_STATUS  4'h8
`define SPG_OFS_ERRCNT  4'hc
`define SPG_CTRL_MODE_LO 0
`define SPG_CTRL_EN      2
`define SPG_CTRL_PCS_REL 3
`define SPG_CTRL_PMA_REL 4
`define SPG_CTRL_RST     5'h00
`define SPG_CMD_INJ      0
`define SPG_CMD_CLR      1
`define SPG_INJ_WORD     32'hffffffef
`define SPG_K285         8'hbc
`define SPG_K285_10B     10'h0fa
`define SPG_PKT_LEN      5'h10
`define SPG_PRBS_SEED    7'h7f
`define SPG_CLK_NS       4
`define SPG_SLIP_GAP_NS  128
`define SPG_SLIP_GAP_CYC (`SPG_SLIP_GAP_NS / `SPG_CLK_NS)
`endif

// >>> hw/spg_pkg.sv
// types shared by the lane pattern generator and checker
package spg_pkg;
  typedef enum logic [1:0] {
    SPG_MODE_8B10B,
    SPG_MODE_PRBS,
    SPG_MODE_SLIP,
    SPG_MODE_NONE
  } spg_mode_t;
  typedef enum logic [1:0] {
    SPG_AL_SEEK,
    SPG_AL_SLIP,
    SPG_AL_GAP,
    SPG_AL_DONE
  } spg_align_t;
endpackage

// >>> hw/spg_top.sv
// lane pattern generator, checker and bit-slip aligner with avalon-mm registers
`include "spg_regs.svh"
module spg_top
  import spg_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [39:0] lane_rx_data_i,
  input  wire logic [3:0]  lane_rx_k_i,
  input  wire logic        lane_rx_valid_i,
  input  wire logic        lane_rx_up_i,
  input  wire logic        lane_tx_up_i,
  input  wire logic        lane_elec_idle_i,
  output logic      [39:0] lane_tx_data_o,
  output logic      [3:0]  lane_tx_k_o,
  output logic             lane_rx_slip_o,
  output logic             lane_coding_reset_n_o,
  output logic             lane_analog_reset_n_o,
  output logic             error_o,
  output logic             lock_o,
  output logic             aligned_o
);
  localparam logic [39:0] COMMA40 = {4{`SPG_K285_10B}};
  localparam logic [5:0]  GAP_CYC = 6'(`SPG_SLIP_GAP_CYC);

  function automatic logic [6:0] prbs_state(input logic [39:0] w);
    logic [6:0] s;
    s = '0;
    for (int k = 0; k < 7; k++) s[6-k] = w[33+k];
    return s;
  endfunction

  function automatic logic [39:0] prbs_word(input logic [6:0] st);
    logic [6:0]  s;
    logic [39:0] w;
    s = st;
    w = '0;
    for (int k = 0; k < 40; k++) begin
      w[k] = s[6] ^ s[5];
      s    = {s[5:0], w[k]};
    end
    return w;
  endfunction

  // bus and control registers
  logic [4:0]  ctrl_r, ctrl_nxt;
  logic        wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        inj_cmd, clr_cmd, req;
  spg_mode_t   mode;
  logic        en;
  logic [31:0] errcnt_r, errcnt_nxt;
  logic        err_seen_r, err_seen_nxt;
  logic        lock_r, lock_nxt;
  logic        error_r, error_nxt;
  logic        aligned_r;
  logic [5:0]  sync1_r, sync2_r;
  logic [43:0] rxw1_r, rxw2_r;

  assign mode    = spg_mode_t'(ctrl_r[`SPG_CTRL_MODE_LO +: 2]);
  assign en      = ctrl_r[`SPG_CTRL_EN];
  assign req     = avs_read_i | avs_write_i;
  assign inj_cmd = avs_write_i & ~wait_r & (avs_address_i == `SPG_OFS_CMD)
                   & avs_byteenable_i[0] & avs_writedata_i[`SPG_CMD_INJ];
  assign clr_cmd = avs_write_i & ~wait_r & (avs_address_i == `SPG_OFS_CMD)
                   & avs_byteenable_i[0] & avs_writedata_i[`SPG_CMD_CLR];

  always_comb begin
    ctrl_nxt  = ctrl_r;
    rdata_nxt = rdata_r;
    wait_nxt  = ~(req & wait_r);
    if (avs_write_i && !wait_r && avs_address_i == `SPG_OFS_CTRL && avs_byteenable_i[0]) begin
      ctrl_nxt = avs_writedata_i[4:0];
    end
    if (avs_read_i && wait_r) begin
      unique case (avs_address_i)
        `SPG_OFS_CTRL:   rdata_nxt = {27'h0, ctrl_r};
        `SPG_OFS_STATUS: rdata_nxt = {26'h0, sync2_r[2:0], aligned_r, err_seen_r, lock_r};
        `SPG_OFS_ERRCNT: rdata_nxt = errcnt_r;
        default:         rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_r  <= `SPG_CTRL_RST;
      wait_r  <= 1'b1;
      rdata_r <= 32'h0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      wait_r  <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // lane inputs pass two flip-flops; data and valid travel together
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sync1_r <= 6'h0;
      sync2_r <= 6'h0;
      rxw1_r  <= 44'h0;
      rxw2_r  <= 44'h0;
    end else begin
      sync1_r <= {2'h0, lane_rx_valid_i, lane_elec_idle_i, lane_tx_up_i, lane_rx_up_i};
      sync2_r <= sync1_r;
      rxw1_r  <= {lane_rx_k_i, lane_rx_data_i};
      rxw2_r  <= rxw1_r;
    end
  end

  logic        rxv;
  logic [39:0] rxd;
  logic [3:0]  rxk;
  assign rxv = sync2_r[3];
  assign rxd = rxw2_r[39:0];
  assign rxk = rxw2_r[43:40];

  // bit-slip aligner
  spg_align_t al_r, al_nxt;
  logic [5:0] gap_r, gap_nxt;
  logic       slip_r, slip_nxt;
  logic       al_act;
  assign al_act = en && mode == SPG_MODE_SLIP;

  always_comb begin
    al_nxt  = al_r;
    gap_nxt = gap_r;
    if (!al_act) begin
      al_nxt = SPG_AL_SEEK;
    end else begin
      unique case (al_r)
        SPG_AL_SEEK: if (rxv) begin
          al_nxt = (rxd == COMMA40) ? SPG_AL_DONE : SPG_AL_SLIP;
        end
        SPG_AL_SLIP: begin
          al_nxt  = SPG_AL_GAP;
          gap_nxt = GAP_CYC;
        end
        SPG_AL_GAP: begin
          gap_nxt = gap_r - 6'h1;
          if (gap_r == 6'h1) al_nxt = SPG_AL_SEEK;
        end
        SPG_AL_DONE: al_nxt = SPG_AL_DONE;
      endcase
    end
    slip_nxt = (al_nxt == SPG_AL_SLIP);
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      al_r      <= SPG_AL_SEEK;
      gap_r     <= 6'h0;
      slip_r    <= 1'b0;
      aligned_r <= 1'b0;
    end else begin
      al_r      <= al_nxt;
      gap_r     <= gap_nxt;
      slip_r    <= slip_nxt;
      aligned_r <= (al_nxt == SPG_AL_DONE);
    end
  end

  // generator
  logic [39:0] tx_r, tx_nxt, cnt_r, cnt_nxt;
  logic [3:0]  txk_r, txk_nxt;
  logic [4:0]  pkt_r, pkt_nxt;
  logic [6:0]  lfsr_r, lfsr_nxt;
  logic        inj_r, inj_nxt, inj_use;
  logic [39:0] cword;

  always_comb begin
    tx_nxt   = 40'h0;
    txk_nxt  = 4'h0;
    cnt_nxt  = cnt_r;
    pkt_nxt  = pkt_r;
    lfsr_nxt = lfsr_r;
    inj_use  = 1'b0;
    cword    = inj_r ? {8'h0, `SPG_INJ_WORD} : cnt_r;
    if (!en) begin
      cnt_nxt  = 40'h0;
      pkt_nxt  = 5'h0;
      lfsr_nxt = `SPG_PRBS_SEED;
    end else begin
      unique case (mode)
        SPG_MODE_8B10B: begin
          if (pkt_r == 5'h0) begin
            tx_nxt  = {8'h0, {4{`SPG_K285}}};
            txk_nxt = 4'hf;
          end else begin
            tx_nxt  = {8'h0, cword[31:0]};
            inj_use = 1'b1;
            cnt_nxt = {8'h0, cnt_r[31:0] + 32'h1};
          end
          pkt_nxt = (pkt_r == `SPG_PKT_LEN) ? 5'h0 : pkt_r + 5'h1;
        end
        SPG_MODE_PRBS: begin
          tx_nxt   = prbs_word(lfsr_r);
          lfsr_nxt = prbs_state(tx_nxt);
        end
        SPG_MODE_SLIP: begin
          if (!aligned_r) begin
            tx_nxt = COMMA40;
          end else begin
            tx_nxt  = cword;
            inj_use = 1'b1;
            cnt_nxt = cnt_r + 40'h1;
          end
        end
        SPG_MODE_NONE: tx_nxt = 40'h0;
      endcase
    end
    inj_nxt = inj_cmd | (inj_r & ~inj_use);
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_r   <= 40'h0;
      txk_r  <= 4'h0;
      cnt_r  <= 40'h0;
      pkt_r  <= 5'h0;
      lfsr_r <= `SPG_PRBS_SEED;
      inj_r  <= 1'b0;
    end else begin
      tx_r   <= tx_nxt;
      txk_r  <= txk_nxt;
      cnt_r  <= cnt_nxt;
      pkt_r  <= pkt_nxt;
      lfsr_r <= lfsr_nxt;
      inj_r  <= inj_nxt;
    end
  end

  // checker
  logic [39:0] exp_r, exp_nxt;
  logic        seed_r, seed_nxt;
  logic        chk_v, comma, mism;

  always_comb begin
    exp_nxt  = exp_r;
    seed_nxt = seed_r;
    lock_nxt = lock_r;
    mism     = 1'b0;
    comma    = (mode == SPG_MODE_8B10B) ? (rxk != 4'h0) : (rxd == COMMA40);
    chk_v    = en && rxv && mode != SPG_MODE_NONE && !(mode != SPG_MODE_PRBS && comma)
               && !(mode == SPG_MODE_SLIP && !aligned_r);
    if (!en) begin
      seed_nxt = 1'b0;
      lock_nxt = 1'b0;
    end else if (chk_v) begin
      if (!seed_r) begin
        seed_nxt = 1'b1;
        exp_nxt  = (mode == SPG_MODE_PRBS) ? prbs_word(prbs_state(rxd)) : rxd;
      end
      if (seed_r) begin
        mism     = (mode == SPG_MODE_8B10B) ? (rxd[31:0] != exp_r[31:0]) : (rxd != exp_r);
        lock_nxt = !mism;
      end
      if (mode == SPG_MODE_PRBS) begin
        exp_nxt = prbs_word(prbs_state(mism || !seed_r ? rxd : exp_r));
      end else if (mode == SPG_MODE_8B10B) begin
        exp_nxt = {8'h0, (seed_r ? exp_r[31:0] : rxd[31:0]) + 32'h1};
      end else begin
        exp_nxt = (seed_r ? exp_r : rxd) + 40'h1;
      end
    end
    error_nxt    = mism;
    err_seen_nxt = mism | (err_seen_r & ~clr_cmd);
    errcnt_nxt   = clr_cmd ? 32'h0 : errcnt_r;
    if (mism) errcnt_nxt = errcnt_nxt + 32'h1;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      exp_r      <= 40'h0;
      seed_r     <= 1'b0;
      lock_r     <= 1'b0;
      error_r    <= 1'b0;
      err_seen_r <= 1'b0;
      errcnt_r   <= 32'h0;
    end else begin
      exp_r      <= exp_nxt;
      seed_r     <= seed_nxt;
      lock_r     <= lock_nxt;
      error_r    <= error_nxt;
      err_seen_r <= err_seen_nxt;
      errcnt_r   <= errcnt_nxt;
    end
  end

  assign avs_readdata_o        = rdata_r;
  assign avs_waitrequest_o     = wait_r;
  assign lane_tx_data_o        = tx_r;
  assign lane_tx_k_o           = txk_r;
  assign lane_rx_slip_o        = slip_r;
  assign lane_coding_reset_n_o = ctrl_r[`SPG_CTRL_PCS_REL];
  assign lane_analog_reset_n_o = ctrl_r[`SPG_CTRL_PMA_REL];
  assign error_o               = error_r;
  assign lock_o                = lock_r;
  assign aligned_o             = aligned_r;

  // checks
  property p_lane_rst;
    @(posedge ref_clk_i) disable iff (rst_i)
    $fell(rst_i) |-> !lane_coding_reset_n_o && !lane_analog_reset_n_o;
  endproperty
  a_lane_rst: assert property (p_lane_rst) else $error("lane not in reset");
  property p_idle;
    @(posedge ref_clk_i) disable iff (rst_i) (!rxv && !clr_cmd) |=> $stable(errcnt_r);
  endproperty
  a_idle: assert property (p_idle) else $error("count moved without valid");
  property p_inj;
    @(posedge ref_clk_i) disable iff (rst_i || !en || mode != SPG_MODE_8B10B)
    inj_cmd |-> ##[1:20] (lane_tx_data_o[31:0] == `SPG_INJ_WORD);
  endproperty
  a_inj: assert property (p_inj) else $error("injected word not sent");
  property p_comma;
    @(posedge ref_clk_i) disable iff (rst_i)
    (en && mode == SPG_MODE_8B10B && pkt_r == 5'h0) |=> lane_tx_k_o == 4'hf;
  endproperty
  a_comma: assert property (p_comma) else $error("comma missing");
  property p_prbs;
    @(posedge ref_clk_i) disable iff (rst_i)
    (en && mode == SPG_MODE_PRBS) [*2] |=>
      lane_tx_data_o == prbs_word(prbs_state($past(lane_tx_data_o)));
  endproperty
  a_prbs: assert property (p_prbs) else $error("prbs stream broken");
  property p_err;
    @(posedge ref_clk_i) disable iff (rst_i) mism |=> error_o && !lock_o;
  endproperty
  a_err: assert property (p_err) else $error("mismatch not flagged");
  property p_clr;
    @(posedge ref_clk_i) disable iff (rst_i) (clr_cmd && !mism) |=> errcnt_r == 32'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("clear ignored");
  property p_slip;
    @(posedge ref_clk_i) disable iff (rst_i)
    (al_act && al_r == SPG_AL_SEEK && rxv && rxd != COMMA40) |=> lane_rx_slip_o ##1 !lane_rx_slip_o;
  endproperty
  a_slip: assert property (p_slip) else $error("slip pulse wrong");
  property p_cnt40;
    @(posedge ref_clk_i) disable iff (rst_i)
    (en && mode == SPG_MODE_SLIP && aligned_r && !inj_r) [*2] |=>
      lane_tx_data_o == $past(lane_tx_data_o) + 40'h1;
  endproperty
  a_cnt40: assert property (p_cnt40) else $error("40-bit counter skipped");
  c_lock: cover property (@(posedge ref_clk_i) disable iff (rst_i) $rose(lock_o));
  c_align: cover property (@(posedge ref_clk_i) disable iff (rst_i) $rose(aligned_o));
  c_err: cover property (@(posedge ref_clk_i) disable iff (rst_i) error_o);
endmodule // spg_top

// >>> bench/spg_lane_model.sv
// loopback model of the transceiver lane parallel fabric interface
module spg_lane_model (
  input  wire logic        ref_clk_i,
  input  wire logic        coding_reset_n_i,
  input  wire logic        analog_reset_n_i,
  input  wire logic [39:0] tx_data_i,
  input  wire logic [3:0]  tx_k_i,
  input  wire logic        slip_i,
  input  wire logic [5:0]  skew_init_i,
  input  wire logic        corrupt_i,
  output logic      [39:0] rx_data_o,
  output logic      [3:0]  rx_k_o,
  output logic             rx_valid_o,
  output logic             up_o,
  output logic             elec_idle_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0]  skew_r;
  logic        slip_q_r;
  logic [79:0] dbl;
  initial rx_data_o = 40'h0;
  assign dbl = {tx_data_i, tx_data_i} >> skew_r;
  assign up_o = coding_reset_n_i & analog_reset_n_i;
  assign elec_idle_o = ~up_o;
  // held lane forgets alignment and shows a changing invalid word
  always @(posedge ref_clk_i or negedge coding_reset_n_i or negedge analog_reset_n_i) begin
    if (!coding_reset_n_i || !analog_reset_n_i) begin
      skew_r     <= skew_init_i;
      slip_q_r   <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_data_o  <= ~rx_data_o;
      rx_k_o     <= 4'h0;
    end else begin
      slip_q_r <= slip_i;
      if (slip_i && !slip_q_r) begin
        skew_r <= (skew_r == 6'h27) ? 6'h00 : skew_r + 6'h01;
      end
      rx_valid_o <= 1'b1;
      rx_data_o  <= dbl[39:0] ^ {39'h0, corrupt_i};
      rx_k_o     <= tx_k_i;
    end
  end
endmodule // spg_lane_model

// >>> bench/serdes_pattern_gen_check_tb_top.sv
// self-checking bench for the lane pattern generator and checker
`include "spg_regs.svh"
module serdes_pattern_gen_check_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i, rst_i, avs_read_i, avs_write_i, corrupt_r, lane_rx_valid_i;
  logic        lane_up, lane_elec_idle_i, lane_rx_slip_o, lane_coding_reset_n_o;
  logic        lane_analog_reset_n_o, error_o, lock_o, aligned_o, avs_waitrequest_o, slip_q;
  logic [3:0]  avs_address_i, avs_byteenable_i, lane_rx_k_i, lane_tx_k_o;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [39:0] lane_rx_data_i, lane_tx_data_o, w, e;
  logic [79:0] s;
  logic [5:0]  skew_r;
  int          errors, compares, err_pulses, slips, e0, s0;
  spg_top i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .lane_rx_data_i(lane_rx_data_i),
    .lane_rx_k_i(lane_rx_k_i), .lane_rx_valid_i(lane_rx_valid_i), .lane_rx_up_i(lane_up),
    .lane_tx_up_i(lane_up), .lane_elec_idle_i(lane_elec_idle_i),
    .lane_tx_data_o(lane_tx_data_o), .lane_tx_k_o(lane_tx_k_o), .lane_rx_slip_o(lane_rx_slip_o),
    .lane_coding_reset_n_o(lane_coding_reset_n_o), .lane_analog_reset_n_o(lane_analog_reset_n_o),
    .error_o(error_o), .lock_o(lock_o), .aligned_o(aligned_o));
  spg_lane_model i_lane (.ref_clk_i(ref_clk_i), .coding_reset_n_i(lane_coding_reset_n_o),
    .analog_reset_n_i(lane_analog_reset_n_o), .tx_data_i(lane_tx_data_o), .tx_k_i(lane_tx_k_o),
    .slip_i(lane_rx_slip_o), .skew_init_i(skew_r), .corrupt_i(corrupt_r),
    .rx_data_o(lane_rx_data_i), .rx_k_o(lane_rx_k_i), .rx_valid_o(lane_rx_valid_i),
    .up_o(lane_up), .elec_idle_o(lane_elec_idle_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  // counts error pulses and rising slip requests
  always @(posedge ref_clk_i) begin
    if (error_o === 1'b1) err_pulses <= err_pulses + 1;
    slip_q <= lane_rx_slip_o;
    if (lane_rx_slip_o === 1'b1 && slip_q !== 1'b1) slips <= slips + 1;
  end
  task automatic close_out();
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_up(input string nm);
    errors++;
    $display("BAD %s expected event seen timeout", nm);
    close_out();
  endtask
  // one avalon access: hold the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    int n;
    @(posedge ref_clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) give_up("waitrequest");
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask
  task automatic wait_tx(input logic [39:0] word);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (lane_tx_data_o !== word && n < 200);
    if (n >= 200) give_up("tx word");
  endtask
  task automatic wait_hi(input bit sel);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while ((sel ? aligned_o : lock_o) !== 1'b1 && n < 1000);
    if (n >= 1000) give_up(sel ? "aligned" : "lock");
  endtask
  initial begin
    errors = 0; compares = 0; err_pulses = 0; slips = 0; slip_q = 1'b0;
    rst_i = 1'b1; avs_read_i = 1'b0; avs_write_i = 1'b0; avs_address_i = 4'h0;
    avs_byteenable_i = 4'hf; avs_writedata_i = 32'h0; skew_r = 6'h00; corrupt_r = 1'b0;
    repeat (10) @(negedge ref_clk_i);
    chk("reset wait", 40'h1, 40'(avs_waitrequest_o));
    chk("reset lane", 40'h0, 40'(lane_coding_reset_n_o));
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
    bus(1'b0, `SPG_OFS_CTRL, 32'h0, q);
    chk("ctrl reset", 40'(`SPG_CTRL_RST), 40'(q));
    bus(1'b0, 4'h2, 32'h0, q);
    chk("unmapped", 40'h0, 40'(q));
    // enabled but lane still held: nothing valid to check
    bus(1'b1, `SPG_OFS_CTRL, 32'h4, q);
    repeat (40) @(negedge ref_clk_i);
    chk("idle lock", 40'h0, 40'(lock_o));
    chk("idle errors", 40'h0, 40'(err_pulses));
    chk("analog held", 40'h0, 40'(lane_analog_reset_n_o));
    bus(1'b1, `SPG_OFS_CTRL, 32'h1c, q);
    wait_tx({8'h00, {4{`SPG_K285}}});
    chk("comma k", 40'hf, 40'(lane_tx_k_o));
    // counter runs on across packets from 0, so each packet starts on a multiple of 16
    for (int i = 0; i < 16; i++) begin
      @(negedge ref_clk_i);
      if (i == 0) w = {8'h00, lane_tx_data_o[31:4], 4'h0};
      chk("tx count", w + 40'(i), lane_tx_data_o);
    end
    @(negedge ref_clk_i);
    chk("packet comma", {8'h00, {4{`SPG_K285}}}, lane_tx_data_o);
    wait_hi(1'b0);
    bus(1'b0, `SPG_OFS_STATUS, 32'h0, q);
    chk("status up", 40'h18, 40'(q & 32'h38));
    e0 = err_pulses;
    bus(1'b1, `SPG_OFS_CMD, 32'h1, q);
    wait_tx(40'(`SPG_INJ_WORD));
    repeat (20) @(negedge ref_clk_i);
    chk("inject pulses", 40'(e0 + 1), 40'(err_pulses));
    chk("relock", 40'h1, 40'(lock_o));
    bus(1'b0, `SPG_OFS_ERRCNT, 32'h0, q);
    chk("inject count", 40'h1, 40'(q));
    bus(1'b1, `SPG_OFS_CMD, 32'h2, q);
    bus(1'b0, `SPG_OFS_ERRCNT, 32'h0, q);
    chk("clear count", 40'h0, 40'(q));
    // prbs: each stream bit follows b[n] = b[n-6] ^ b[n-7], bit 0 first
    bus(1'b1, `SPG_OFS_CTRL, 32'h0, q);
    bus(1'b1, `SPG_OFS_CMD, 32'h2, q);
    e0 = err_pulses;
    // enable first with the lane held, so the first valid word is real stream data
    bus(1'b1, `SPG_OFS_CTRL, 32'h5, q);
    bus(1'b1, `SPG_OFS_CTRL, 32'h1d, q);
    wait_hi(1'b0);
    @(negedge ref_clk_i);
    w = lane_tx_data_o;
    for (int k = 0; k < 8; k++) begin
      @(negedge ref_clk_i);
      s = {lane_tx_data_o, w};
      for (int j = 40; j < 80; j++) e[j - 40] = s[j - 6] ^ s[j - 7];
      chk("prbs word", e, lane_tx_data_o);
      w = lane_tx_data_o;
    end
    chk("prbs clean", 40'(e0), 40'(err_pulses));
    @(posedge ref_clk_i);
    corrupt_r <= 1'b1;
    @(posedge ref_clk_i);
    corrupt_r <= 1'b0;
    wait_hi(1'b0);
    repeat (10) @(negedge ref_clk_i);
    chk("prbs error", 40'(e0 + 1), 40'(err_pulses));
    bus(1'b0, `SPG_OFS_ERRCNT, 32'h0, q);
    chk("prbs count", 40'h1, 40'(q));
    // slip: lane starts three bits off the word boundary
    bus(1'b1, `SPG_OFS_CTRL, 32'h0, q);
    skew_r <= 6'h25;
    bus(1'b1, `SPG_OFS_CMD, 32'h2, q);
    s0 = slips;
    e0 = err_pulses;
    bus(1'b1, `SPG_OFS_CTRL, 32'h1e, q);
    wait_hi(1'b1);
    chk("slip count", 40'h3, 40'(slips - s0));
    repeat (4) @(negedge ref_clk_i);
    w = lane_tx_data_o;
    for (int k = 0; k < 10; k++) begin
      @(negedge ref_clk_i);
      chk("slip counter", w + 40'h1, lane_tx_data_o);
      w = lane_tx_data_o;
    end
    wait_hi(1'b0);
    repeat (10) @(negedge ref_clk_i);
    chk("slip errors", 40'(e0), 40'(err_pulses));
    // off mode: nothing sent, no slip requests
    s0 = slips;
    bus(1'b1, `SPG_OFS_CTRL, 32'h1f, q);
    repeat (40) @(negedge ref_clk_i);
    chk("off tx", 40'h0, lane_tx_data_o);
    chk("off slips", 40'(s0), 40'(slips));
    close_out();
  end
endmodule // serdes_pattern_gen_check_tb_top
